// ==== serial_txrx_pkg.sv ====
// package for the serial transmit/receive data path
// assumes a sample-rate tick from an external baud generator
package serial_txrx_pkg;

  // ==========================================================
  // timing and frame geometry
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] SPI_TICKS_PER_BIT = 5'h02;
  localparam logic [3:0] SPI_BITS = 4'h8;
  localparam logic [3:0] MIN_DATA_BITS = 4'h5;
  localparam logic [3:0] MAX_DATA_BITS = 4'h9;
  localparam int RX_FIFO_DEPTH = 8;
  localparam int FRAME_W = 13;

  // ==========================================================
  // parity selection codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] data_bits;
    logic [1:0] parity;
    logic two_stop;
    logic double_speed;
    logic spi_mode;
    logic spi_lsb_first;
  } frame_cfg_s;

  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic parity_err;
    logic overflow;
  } rx_word_s;

  localparam int RX_WORD_W = $bits(rx_word_s);

endpackage : serial_txrx_pkg

// ==== serial_fifo.sv ====
// synchronous fifo with valid/ready on both sides and a flush
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
module serial_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o = mem_ff[rd_ff];
  assign push = in_valid_i && in_ready_o && !flush_i;
  assign pop = out_valid_o && out_ready_i && !flush_i;

  always_comb begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (flush_i) begin
      nxt_wr = '0;
      nxt_rd = '0;
      nxt_cnt = '0;
    end else begin
      if (push) begin
        nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
      end
      nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset; empty flag hides stale contents
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

endmodule : serial_fifo

// ==== serial_txrx_datapath.sv ====
// transmit and receive data path of a serial transceiver
// assumes baud_tick_i pulses at the sample rate (16x/8x baud),
// or at twice the bit rate in master spi mode
`timescale 1ns/100ps
module serial_txrx_datapath (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic baud_tick_i,
  input wire serial_txrx_pkg::frame_cfg_s cfg_i,
  input wire logic pin_invert_setting_i,
  input wire logic tx_enable_i,
  input wire logic rx_enable_i,
  input wire logic tx_write_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_ninth_bit_i,
  input wire logic tx_complete_clear_i,
  output logic tx_buffer_empty_flag_o,
  output logic tx_complete_flag_o,
  output logic serial_out_pin_n_o,
  output logic serial_out_oe_o,
  output logic sync_clock_pin_o,
  input wire logic serial_in_pin_i,
  input wire logic rx_read_i,
  output logic rx_complete_flag_o,
  output logic [7:0] rx_data_o,
  output logic rx_ninth_bit_o,
  output logic frame_error_flag_o,
  output logic parity_error_flag_o,
  output logic rx_overflow_flag_o
);
  localparam int FW = serial_txrx_pkg::FRAME_W;

  typedef enum {TX_IDLE, TX_BUSY} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_TAIL} rx_state_e;

  // ==========================================================
  // shared helpers
  logic [3:0] nbits;
  logic par_en;
  logic [4:0] spb;
  logic [4:0] vfirst;

  always_comb begin
    nbits = cfg_i.data_bits;
    if (nbits < serial_txrx_pkg::MIN_DATA_BITS ||
        nbits > serial_txrx_pkg::MAX_DATA_BITS) begin
      nbits = serial_txrx_pkg::SPI_BITS;
    end
    par_en = cfg_i.parity[1];
    spb = cfg_i.double_speed ? serial_txrx_pkg::SAMPLES_DOUBLE
                             : serial_txrx_pkg::SAMPLES_NORMAL;
    vfirst = cfg_i.double_speed ? serial_txrx_pkg::VOTE_FIRST_DOUBLE
                                : serial_txrx_pkg::VOTE_FIRST_NORMAL;
  end

  function automatic logic [8:0] mask_data(input logic [8:0] d,
                                           input logic [3:0] n);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++) begin
      m[i] = (i < int'(n)) ? d[i] : 1'b0;
    end
    return m;
  endfunction : mask_data

  // ==========================================================
  // receive fifo
  logic push_valid, push_ready;
  serial_txrx_pkg::rx_word_s push_word, head_word;

  serial_fifo #(
    .WIDTH(serial_txrx_pkg::RX_WORD_W),
    .DEPTH(serial_txrx_pkg::RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .flush_i(!rx_enable_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_word),
    .out_valid_o(rx_complete_flag_o),
    .out_ready_i(rx_read_i),
    .out_data_o(head_word)
  );

  // flags are those of the head frame; a read pops them too
  assign rx_data_o = head_word.data[7:0];
  assign rx_ninth_bit_o = head_word.data[8];
  assign frame_error_flag_o = head_word.frame_err;
  assign parity_error_flag_o = head_word.parity_err;
  assign rx_overflow_flag_o = head_word.overflow;

  // ==========================================================
  // transmitter
  tx_state_e tx_state_ff, nxt_tx_state;
  logic [FW-1:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_left_ff, nxt_tx_left;
  logic [4:0] tx_tick_ff, nxt_tx_tick;
  logic [8:0] tx_buf_ff, nxt_tx_buf;
  logic tx_full_ff, nxt_tx_full;
  logic tx_cmpl_ff, nxt_tx_cmpl;
  logic tx_on_ff, nxt_tx_on;
  logic [7:0] spi_rx_ff, nxt_spi_rx;
  logic spi_push;
  logic [4:0] tx_len;

  function automatic logic [FW-1:0] build_frame(
      input logic [8:0] d, input serial_txrx_pkg::frame_cfg_s c,
      input logic [3:0] n);
    logic [FW-1:0] f;
    logic [8:0] m;
    logic [3:0] idx;
    f = '1;
    m = mask_data(d, n);
    idx = n + 4'h1;
    if (c.spi_mode) begin
      for (int i = 0; i < 8; i++) begin
        f[i] = c.spi_lsb_first ? d[i] : d[7-i];
      end
    end else begin
      f[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
        if (i < int'(n)) begin
          f[i+1] = m[i];
        end
      end
      if (c.parity == serial_txrx_pkg::PAR_EVEN) begin
        f[idx] = ^m;
      end else if (c.parity == serial_txrx_pkg::PAR_ODD) begin
        f[idx] = ~^m;
      end
    end
    return f;
  endfunction : build_frame

  always_comb begin
    tx_len = 5'h1 + {1'b0, nbits} + {4'h0, par_en} + 5'h1 +
             {4'h0, cfg_i.two_stop};
    if (cfg_i.spi_mode) begin
      tx_len = {1'b0, serial_txrx_pkg::SPI_BITS};
    end
  end

  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_left = tx_left_ff;
    nxt_tx_tick = tx_tick_ff;
    nxt_tx_buf = tx_buf_ff;
    nxt_tx_full = tx_full_ff;
    nxt_tx_cmpl = tx_cmpl_ff;
    nxt_spi_rx = spi_rx_ff;
    spi_push = 1'b0;
    // stay on while anything is queued or shifting
    nxt_tx_on = tx_enable_i || tx_full_ff ||
                (tx_state_ff == TX_BUSY);
    if (tx_write_i && !tx_full_ff && tx_enable_i) begin
      nxt_tx_buf = {tx_ninth_bit_i, tx_data_i};
      nxt_tx_full = 1'b1;
    end
    case (tx_state_ff)
      TX_IDLE: begin
        if (tx_full_ff) begin
          nxt_tx_sh = build_frame(tx_buf_ff, cfg_i, nbits);
          nxt_tx_left = tx_len[3:0];
          nxt_tx_tick = '0;
          nxt_tx_full = 1'b0;
          nxt_tx_state = TX_BUSY;
        end
      end
      TX_BUSY: begin
        if (baud_tick_i) begin
          nxt_tx_tick = tx_tick_ff + 5'h1;
          if (cfg_i.spi_mode && tx_tick_ff == '0) begin
            nxt_spi_rx = cfg_i.spi_lsb_first ?
                {serial_in_pin_i, spi_rx_ff[7:1]} :
                {spi_rx_ff[6:0], serial_in_pin_i};
          end
          if (nxt_tx_tick == (cfg_i.spi_mode ?
              serial_txrx_pkg::SPI_TICKS_PER_BIT : spb)) begin
            nxt_tx_tick = '0;
            nxt_tx_sh = {1'b1, tx_sh_ff[FW-1:1]};
            nxt_tx_left = tx_left_ff - 4'h1;
            if (tx_left_ff == 4'h1) begin
              spi_push = cfg_i.spi_mode;
              if (tx_full_ff) begin
                // back-to-back: reload right after last bit
                nxt_tx_sh = build_frame(tx_buf_ff, cfg_i, nbits);
                nxt_tx_left = tx_len[3:0];
                nxt_tx_full = 1'b0;
              end else begin
                nxt_tx_state = TX_IDLE;
                nxt_tx_cmpl = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        nxt_tx_state = TX_IDLE;
      end
    endcase
    // a completion in the same cycle beats the clear
    if (tx_complete_clear_i &&
        !(tx_state_ff == TX_BUSY && nxt_tx_state == TX_IDLE)) begin
      nxt_tx_cmpl = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_state_ff <= TX_IDLE;
      tx_sh_ff <= '1;
      tx_left_ff <= '0;
      tx_tick_ff <= '0;
      tx_buf_ff <= '0;
      tx_full_ff <= 1'b0;
      tx_cmpl_ff <= 1'b0;
      tx_on_ff <= 1'b0;
      spi_rx_ff <= '0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_sh_ff <= nxt_tx_sh;
      tx_left_ff <= nxt_tx_left;
      tx_tick_ff <= nxt_tx_tick;
      tx_buf_ff <= nxt_tx_buf;
      tx_full_ff <= nxt_tx_full;
      tx_cmpl_ff <= nxt_tx_cmpl;
      tx_on_ff <= nxt_tx_on;
      spi_rx_ff <= nxt_spi_rx;
    end
  end

  assign tx_buffer_empty_flag_o = !tx_full_ff;
  assign tx_complete_flag_o = tx_cmpl_ff;
  // idle level is high between frames
  assign serial_out_pin_n_o = (tx_state_ff == TX_BUSY) ? tx_sh_ff[0]
                                                       : 1'b1;
  assign serial_out_oe_o = tx_on_ff;
  // second half of each bit is the sampling edge
  assign sync_clock_pin_o = (cfg_i.spi_mode && tx_state_ff == TX_BUSY &&
                             tx_tick_ff != '0) ^
                            pin_invert_setting_i;

  // ==========================================================
  // asynchronous receiver
  rx_state_e rx_state_ff, nxt_rx_state;
  logic [4:0] rx_smp_ff, nxt_rx_smp;
  logic [1:0] rx_vote_ff, nxt_rx_vote;
  logic rx_prev_ff, nxt_rx_prev;
  logic [3:0] rx_idx_ff, nxt_rx_idx;
  logic [8:0] rx_sh_ff, nxt_rx_sh;
  logic rx_par_ff, nxt_rx_par;
  logic ovf_pend_ff, nxt_ovf_pend;
  logic [4:0] smp;
  logic maj;
  logic exp_par;
  logic async_push;
  serial_txrx_pkg::rx_word_s async_word;

  always_comb begin
    nxt_rx_state = rx_state_ff;
    nxt_rx_smp = rx_smp_ff;
    nxt_rx_vote = rx_vote_ff;
    nxt_rx_prev = rx_prev_ff;
    nxt_rx_idx = rx_idx_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_par = rx_par_ff;
    async_push = 1'b0;
    async_word = '0;
    smp = (rx_smp_ff == spb) ? 5'h1 : rx_smp_ff + 5'h1;
    maj = (rx_vote_ff[0] & rx_vote_ff[1]) |
          (rx_vote_ff[0] & serial_in_pin_i) |
          (rx_vote_ff[1] & serial_in_pin_i);
    exp_par = (^mask_data(rx_sh_ff, nbits)) ^ cfg_i.parity[0];
    if (baud_tick_i) begin
      case (rx_state_ff)
        RX_IDLE: begin
          nxt_rx_prev = serial_in_pin_i;
          if (rx_prev_ff && !serial_in_pin_i) begin
            nxt_rx_smp = 5'h1; // first low sample is sample 1
            nxt_rx_state = RX_START;
          end
        end
        RX_START, RX_DATA: begin
          nxt_rx_smp = smp;
          if (smp == vfirst) begin
            nxt_rx_vote[0] = serial_in_pin_i;
          end else if (smp == vfirst + 5'h1) begin
            nxt_rx_vote[1] = serial_in_pin_i;
          end else if (smp == vfirst + 5'h2) begin
            if (rx_state_ff == RX_START) begin
              nxt_rx_idx = '0;
              nxt_rx_sh = '0;
              // high majority is a noise spike: rearm
              nxt_rx_state = maj ? RX_IDLE : RX_DATA;
              nxt_rx_prev = 1'b1;
            end else if (rx_idx_ff < nbits) begin
              nxt_rx_sh[rx_idx_ff] = maj;
              nxt_rx_idx = rx_idx_ff + 4'h1;
            end else if (par_en && rx_idx_ff == nbits) begin
              nxt_rx_par = maj;
              nxt_rx_idx = rx_idx_ff + 4'h1;
            end else begin
              // first stop bit ends the frame; a second is not waited on
              async_push = 1'b1;
              async_word.data = rx_sh_ff;
              async_word.frame_err = !maj;
              async_word.parity_err = par_en &&
                                      (exp_par != rx_par_ff);
              nxt_rx_prev = serial_in_pin_i;
              nxt_rx_state = cfg_i.double_speed ? RX_TAIL
                                                : RX_IDLE;
            end
          end
        end
        RX_TAIL: begin
          // double speed needs one more sample before a new edge
          nxt_rx_prev = serial_in_pin_i;
          nxt_rx_state = RX_IDLE;
        end
        default: begin
          nxt_rx_state = RX_IDLE;
        end
      endcase
    end
    if (!rx_enable_i || cfg_i.spi_mode) begin
      nxt_rx_state = RX_IDLE;
      nxt_rx_prev = 1'b1;
      async_push = 1'b0;
    end
  end

  // ==========================================================
  // fifo fill and overflow marking
  always_comb begin
    push_word = async_word;
    if (spi_push) begin
      push_word = '0;
      push_word.data = {1'b0, spi_rx_ff};
    end
    push_word.overflow = ovf_pend_ff;
    push_valid = (async_push || (spi_push && rx_enable_i));
    nxt_ovf_pend = ovf_pend_ff;
    if (push_valid && push_ready) begin
      nxt_ovf_pend = 1'b0;
    end else if (push_valid) begin
      nxt_ovf_pend = 1'b1;
    end
    if (!rx_enable_i) begin
      nxt_ovf_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rx_state_ff <= RX_IDLE;
      rx_smp_ff <= '0;
      rx_vote_ff <= '0;
      rx_prev_ff <= 1'b1;
      rx_idx_ff <= '0;
      rx_sh_ff <= '0;
      rx_par_ff <= 1'b0;
      ovf_pend_ff <= 1'b0;
    end else begin
      rx_state_ff <= nxt_rx_state;
      rx_smp_ff <= nxt_rx_smp;
      rx_vote_ff <= nxt_rx_vote;
      rx_prev_ff <= nxt_rx_prev;
      rx_idx_ff <= nxt_rx_idx;
      rx_sh_ff <= nxt_rx_sh;
      rx_par_ff <= nxt_rx_par;
      ovf_pend_ff <= nxt_ovf_pend;
    end
  end

endmodule : serial_txrx_datapath

// ==== serial_txrx_sva.sv ====
// checker for the serial data path, watching top-level ports only
// assumes it is bound to serial_txrx_datapath
`timescale 1ns/100ps
module serial_txrx_sva (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire serial_txrx_pkg::frame_cfg_s cfg_i,
  input wire logic tx_enable_i,
  input wire logic rx_enable_i,
  input wire logic tx_write_i,
  input wire logic tx_complete_clear_i,
  input wire logic tx_buffer_empty_flag_o,
  input wire logic tx_complete_flag_o,
  input wire logic serial_out_pin_n_o,
  input wire logic serial_out_oe_o,
  input wire logic rx_complete_flag_o,
  input wire logic [7:0] rx_data_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ========
  // transmit side
  AST_WR_TAKEN: assert property (
    tx_write_i && tx_enable_i && tx_buffer_empty_flag_o
    |=> !tx_buffer_empty_flag_o) else $error("write not taken");
  AST_WR_REFUSED: assert property (
    tx_write_i && !tx_enable_i && tx_buffer_empty_flag_o
    |=> tx_buffer_empty_flag_o) else $error("write taken while off");
  // a tick can come every cycle, so eight cycles is the shortest start
  AST_LOAD_START: assert property (
    $rose(tx_buffer_empty_flag_o) && !cfg_i.spi_mode
    |-> !serial_out_pin_n_o [*8]) else $error("no start bit on load");
  AST_TXC_SET: assert property (
    $rose(tx_complete_flag_o)
    |-> tx_buffer_empty_flag_o && serial_out_pin_n_o)
    else $error("complete while data pending");
  AST_TXC_STICKY: assert property (
    tx_complete_flag_o && !tx_complete_clear_i |=> tx_complete_flag_o)
    else $error("complete flag lost");
  AST_OE_ON: assert property (
    tx_enable_i && $past(tx_enable_i) && $past(nrst_i)
    |-> serial_out_oe_o) else $error("pin not driven");
  AST_OE_OFF: assert property (
    $fell(serial_out_oe_o) |-> !$past(tx_enable_i) && tx_buffer_empty_flag_o)
    else $error("pin released early");
  // ========
  // receive side
  AST_RX_FLUSH: assert property (
    !rx_enable_i |=> !rx_complete_flag_o) else $error("no flush");
  AST_RX_UNUSED: assert property (
    rx_complete_flag_o && !cfg_i.spi_mode
    && cfg_i.data_bits inside {4'h5, 4'h6, 4'h7}
    |-> (rx_data_o >> cfg_i.data_bits) == 8'h00)
    else $error("unused bits not zero");
  COV_TXC: cover property ($rose(tx_complete_flag_o));
  COV_RXC: cover property ($rose(rx_complete_flag_o));
  COV_OE_OFF: cover property ($fell(serial_out_oe_o));
endmodule : serial_txrx_sva

// ==== remote_serial_model.sv ====
// remote serial station: sends frames and captures transmitted ones
// assumes baud_tick_i is the sample tick shared with the device
`timescale 1ns/100ps
module remote_serial_model (
  input wire logic clk_i,
  input wire logic baud_tick_i,
  input wire logic from_dut_i,
  output logic to_dut_o
);
  initial to_dut_o = 1'b1; // line idles high
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk_i);
      while (!baud_tick_i) @(posedge clk_i);
    end
  endtask : tk
  // bit 0 is the start bit; caller builds data, parity and stop
  task automatic send(input logic [11:0] b, input int nb, input int spb);
    tk(1);
    for (int i = 0; i < nb; i++) begin
      to_dut_o <= b[i];
      tk(spb);
    end
    to_dut_o <= 1'b1;
    tk(spb);
  endtask : send
  // samples each bit at its centre after the falling start edge
  task automatic grab(output logic [11:0] b, input int nb, input int spb);
    int w;
    b = 12'h000;
    w = 0;
    while (from_dut_i !== 1'b0 && w < 20000) begin
      @(posedge clk_i);
      w++;
    end
    tk(spb / 2);
    for (int i = 0; i < nb; i++) begin
      b[i] = from_dut_i;
      tk(spb);
    end
  endtask : grab
endmodule : remote_serial_model

// ==== serial_txrx_datapath_bench.sv ====
// bench for the serial data path: async tx/rx, fifo, spi loopback
// assumes the package, the remote station model and the checker
`timescale 1ns/100ps
module serial_txrx_datapath_bench;
  logic clk_i, nrst_i, tick, inv, ten, ren, wrs, t9, tcc, rdp, sin, pin;
  logic txe, txc, so, oe, sck, rxc, r9, fe, pe, ov;
  logic [7:0] td, rd, b8;
  logic [11:0] e, g;
  int nb, spb, w;
  int n_errors = 0;
  int samples_checked = 0;
  serial_txrx_pkg::frame_cfg_s cfg;
  serial_txrx_pkg::frame_cfg_s tab [5] = '{10'h200, 10'h160, 10'h1F8,
      10'h26C, 10'h1B4};
  logic [8:0] val [5] = '{9'h0A5, 9'h0C5, 9'h03B, 9'h1D3, 9'h02C};
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial tick = 1'b0;
  always @(posedge clk_i) tick <= ~tick;
  // spi frames loop back so the receiver sees what was sent
  assign sin = cfg.spi_mode ? so : pin;
  serial_txrx_datapath u_serial_txrx_datapath (.clk_i(clk_i),
    .nrst_i(nrst_i), .baud_tick_i(tick), .cfg_i(cfg),
    .pin_invert_setting_i(inv), .tx_enable_i(ten), .rx_enable_i(ren),
    .tx_write_i(wrs), .tx_data_i(td), .tx_ninth_bit_i(t9),
    .tx_complete_clear_i(tcc), .tx_buffer_empty_flag_o(txe),
    .tx_complete_flag_o(txc), .serial_out_pin_n_o(so),
    .serial_out_oe_o(oe), .sync_clock_pin_o(sck), .serial_in_pin_i(sin),
    .rx_read_i(rdp), .rx_complete_flag_o(rxc), .rx_data_o(rd),
    .rx_ninth_bit_o(r9), .frame_error_flag_o(fe),
    .parity_error_flag_o(pe), .rx_overflow_flag_o(ov));
  remote_serial_model u_remote_serial_model (.clk_i(clk_i),
    .baud_tick_i(tick), .from_dut_i(so), .to_dut_o(pin));
  // ========
  // helpers
  task automatic chk(input string nm, input logic [11:0] gt,
      input logic [11:0] ex);
    samples_checked++;
    if (gt !== ex) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, gt);
    end
  endtask : chk
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // ninth bit and low byte go in one pulse
  task automatic wr(input logic [8:0] v);
    w = 0;
    while (txe !== 1'b1 && w < 5000) begin
      @(posedge clk_i);
      w++;
    end
    t9 <= v[8];
    td <= v[7:0];
    wrs <= 1'b1;
    @(posedge clk_i);
    wrs <= 1'b0;
  endtask : wr
  task automatic pop();
    rdp <= 1'b1;
    @(posedge clk_i);
    rdp <= 1'b0;
    @(posedge clk_i);
  endtask : pop
  function automatic logic [11:0] mk(input logic [8:0] v,
      input serial_txrx_pkg::frame_cfg_s c, input logic bad,
      output int n);
    logic [11:0] b;
    logic p;
    b = 12'h000;
    p = c.parity[0];
    for (int i = 0; i < int'(c.data_bits); i++) begin
      b[i + 1] = v[i];
      p = p ^ v[i];
    end
    n = int'(c.data_bits) + 1;
    if (c.parity[1]) begin
      b[n] = p ^ bad;
      n++;
    end
    b[n] = ~bad;
    n++;
    return b;
  endfunction : mk
  // low phase value just before each rising clock edge
  task automatic spi_cap(input logic lsb, output logic [7:0] b);
    logic pv, ps;
    b = 8'h00;
    for (int j = 0; j < 8; j++) begin
      w = 0;
      do begin
        pv = sck ^ inv;
        ps = so;
        @(posedge clk_i);
        w++;
      end while (!((sck ^ inv) && !pv) && w < 64);
      b = lsb ? {ps, b[7:1]} : {b[6:0], ps};
    end
  endtask : spi_cap
  // ========
  // tests
  initial begin
    nrst_i = 1'b0;
    cfg = tab[0];
    {inv, ten, ren, wrs, t9, tcc, rdp} = 7'h00;
    td = 8'h00;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("reset", {txe, txc, so, oe, rxc}, 12'h014);
    ten <= 1'b1;
    ren <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      cfg <= tab[i];
      spb = tab[i].double_speed ? 8 : 16;
      e = mk(val[i], tab[i], 1'b0, nb);
      @(posedge clk_i);
      fork
        u_remote_serial_model.grab(g, nb, spb);
        begin
          wr(val[i]);
          ten <= (i != 0);
        end
      join
      chk("tx frame", g, e);
      u_remote_serial_model.tk(2 * spb);
      chk("tx done", {txc, oe}, {11'h001, i != 0});
      if (i == 0) begin
        wr(9'h155);
        @(posedge clk_i);
        chk("refused", {txe, oe}, 12'h002);
      end
      tcc <= 1'b1;
      ten <= 1'b1;
      @(posedge clk_i);
      tcc <= 1'b0;
      u_remote_serial_model.send(e, nb, spb);
      chk("rx good", {ov, fe, pe, r9, rd},
          {3'h0, val[i] & ((9'h001 << tab[i].data_bits) - 9'h001)});
      pop();
      e = mk(val[i], tab[i], 1'b1, nb);
      u_remote_serial_model.send(e, nb, spb);
      chk("rx bad", {fe, pe}, {11'h001, tab[i].parity[1]});
      pop();
      chk("rx empty", rxc, 12'h000);
    end
    // noise spike of eight low samples must be rejected
    cfg <= tab[0];
    u_remote_serial_model.send(12'h000, 1, 8);
    for (int k = 0; k < 9; k++) begin
      e = mk(9'(k), tab[0], 1'b0, nb);
      u_remote_serial_model.send(e, nb, 16);
    end
    for (int k = 0; k < 8; k++) begin
      chk("fifo", {ov, rd}, 12'(k));
      pop();
    end
    e = mk(9'h0FF, tab[0], 1'b0, nb);
    u_remote_serial_model.send(e, nb, 16);
    chk("overflow", {ov, rd}, 12'h1FF);
    ren <= 1'b0;
    @(posedge clk_i);
    ren <= 1'b1;
    @(posedge clk_i);
    chk("flush", rxc, 12'h000);
    for (int s = 0; s < 2; s++) begin
      cfg <= 10'h202 | 10'(s);
      inv <= s[0];
      @(posedge clk_i);
      fork
        spi_cap(s[0], b8);
        wr(9'h04D);
      join
      chk("spi tx", b8, 12'h04D);
      w = 0;
      while (txc !== 1'b1 && w < 200) begin
        @(posedge clk_i);
        w++;
      end
      @(posedge clk_i);
      chk("spi end", {txc, so, rxc, sck, rd}, {3'h7, s[0], 8'h4D});
      pop();
      tcc <= 1'b1;
      @(posedge clk_i);
      tcc <= 1'b0;
    end
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end
endmodule : serial_txrx_datapath_bench
bind serial_txrx_datapath serial_txrx_sva u_serial_txrx_sva (
  .clk_i(clk_i), .nrst_i(nrst_i), .cfg_i(cfg_i),
  .tx_enable_i(tx_enable_i), .rx_enable_i(rx_enable_i),
  .tx_write_i(tx_write_i), .tx_complete_clear_i(tx_complete_clear_i),
  .tx_buffer_empty_flag_o(tx_buffer_empty_flag_o),
  .tx_complete_flag_o(tx_complete_flag_o),
  .serial_out_pin_n_o(serial_out_pin_n_o),
  .serial_out_oe_o(serial_out_oe_o),
  .rx_complete_flag_o(rx_complete_flag_o), .rx_data_o(rx_data_o));
